/* logic/mhbp_pkg.sv */
package mhbp_pkg;
  localparam int unsigned      MHBP_CLK_NS       = 10;
  localparam int unsigned      MHBP_INT_PULSE_NS = 20;
  localparam int unsigned      MHBP_INT_PULSE_CYC_I =
    (MHBP_INT_PULSE_NS + MHBP_CLK_NS - 1) / MHBP_CLK_NS;
  localparam int unsigned      MHBP_PCNT_W       = 3;
  localparam logic [2:0]       MHBP_INT_PULSE_CYC =
    (MHBP_INT_PULSE_CYC_I < 1) ? 3'h1 : MHBP_INT_PULSE_CYC_I[2:0];
  localparam logic [2:0]       MHBP_PCNT_ZERO    = 3'h0;
  localparam logic [2:0]       MHBP_PCNT_ONE     = 3'h1;
  localparam int unsigned      MHBP_DATA_W       = 8;
  localparam int unsigned      MHBP_MEM_BYTES    = 256;
  localparam logic [7:0]       MHBP_BYTE_ZERO    = 8'h00;
  localparam logic [7:0]       MHBP_CTRL_LAST    = 8'h0A;
  localparam logic [7:0]       MHBP_CHAN_FIRST   = 8'h10;
  localparam logic [7:0]       MHBP_CHAN_LAST    = 8'h7F;
  localparam logic [7:0]       MHBP_RAM_FIRST    = 8'h80;
  localparam logic [7:0]       MHBP_IRQ_FIRST    = 8'h08;
  localparam logic [7:0]       MHBP_IRQ_LAST     = 8'h0B;
  typedef enum logic [1:0] {
    MHBP_OP_IDLE   = 2'b00,
    MHBP_OP_READ   = 2'b01,
    MHBP_OP_WR_SEP = 2'b10,
    MHBP_OP_WR_EN  = 2'b11
  } mhbp_op_t;
  typedef enum logic [1:0] {
    MHBP_RG_CTRL = 2'b00,
    MHBP_RG_CHAN = 2'b01,
    MHBP_RG_RAM  = 2'b10,
    MHBP_RG_NONE = 2'b11
  } mhbp_region_t;
endpackage

/* logic/mhbp_sync.sv */
`timescale 1ns/1ps
module mhbp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         CORE_CLK,
  input  wire logic         ARST_N,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mhbp_sync_t;
  mhbp_sync_t st_r;
  mhbp_sync_t st_nxt;
  // first stage read only by second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = D;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign Q = st_r.s2;
endmodule

/* logic/mhbp_port.sv */
`timescale 1ns/1ps
module mhbp_port
  import mhbp_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       ARST_N,
  input  wire logic [7:0] MUXED_BUS_I,
  output logic      [7:0] MUXED_BUS_O,
  output logic            MUXED_BUS_OE,
  input  wire logic       ADDR_LATCH,
  input  wire logic       READ_N,
  input  wire logic       WRITE_DIR,
  input  wire logic       SELECT_EN,
  input  wire logic       IRQ_PENDING,
  input  wire logic       IRQ_CLEARED,
  output logic            INT_N_O,
  output logic            INT_N_OE,
  output logic            BUFFERED_CLOCK_OUT,
  output logic            BUFFERED_CLOCK_OE,
  output logic            CORE_WR_STB,
  output logic            CORE_RD_STB,
  output logic      [7:0] CORE_ADDR,
  output logic      [7:0] CORE_WDATA,
  output logic      [1:0] CORE_REGION
);
  typedef struct packed {
    logic [MHBP_MEM_BYTES-1:0][MHBP_DATA_W-1:0] mem;
    logic [7:0]             addr;
    logic [7:0]             wdata;
    logic                   ale_d;
    mhbp_op_t               op;
    logic [7:0]             dout;
    logic                   doe;
    logic [MHBP_PCNT_W-1:0] pcnt;
    logic                   int_oe;
    logic                   buffered_clock_out;
    logic                   ck_oe;
    logic                   wr_stb;
    logic                   rd_stb;
    logic [7:0]             core_addr;
    logic [7:0]             core_wdata;
    mhbp_region_t           region;
  } mhbp_state_t;

  mhbp_state_t st_r;
  mhbp_state_t st_nxt;
  logic [7:0]  bus_s;
  logic [3:0]  ctl_s;
  logic        ale_s;
  logic        rd_n_s;
  logic        wr_s;
  logic        cs_s;
  mhbp_op_t    op_now;
  logic        start;
  logic        irq_hit;

  // address space map
  function automatic mhbp_region_t region_of(input logic [7:0] a);
    mhbp_region_t r;
    r = MHBP_RG_NONE;
    if (a <= MHBP_CTRL_LAST) begin
      r = MHBP_RG_CTRL;
    end else if (a >= MHBP_CHAN_FIRST && a <= MHBP_CHAN_LAST) begin
      r = MHBP_RG_CHAN;
    end else if (a >= MHBP_RAM_FIRST) begin
      r = MHBP_RG_RAM;
    end
    return r;
  endfunction

  function automatic logic is_irq_reg(input logic [7:0] a);
    return (a >= MHBP_IRQ_FIRST) && (a <= MHBP_IRQ_LAST);
  endfunction

  // pins pass two flops
  mhbp_sync #(.W(MHBP_DATA_W)) u_bus_sync (
    .CORE_CLK (CORE_CLK),
    .ARST_N   (ARST_N),
    .D        (MUXED_BUS_I),
    .Q        (bus_s)
  );
  mhbp_sync #(.W(4)) u_ctl_sync (
    .CORE_CLK (CORE_CLK),
    .ARST_N   (ARST_N),
    .D        ({ADDR_LATCH, READ_N, WRITE_DIR, SELECT_EN}),
    .Q        (ctl_s)
  );
  assign ale_s  = ctl_s[3];
  assign rd_n_s = ctl_s[2];
  assign wr_s   = ctl_s[1];
  assign cs_s   = ctl_s[0];

  // access mode decode, timed by command or enable strobe
  always_comb begin
    op_now = MHBP_OP_IDLE;
    if (cs_s) begin
      unique case ({rd_n_s, wr_s})
        2'b00: begin
          op_now = MHBP_OP_WR_EN;
        end
        2'b01: begin
          op_now = MHBP_OP_READ;
        end
        2'b10: begin
          op_now = MHBP_OP_WR_SEP;
        end
        2'b11: begin
          op_now = MHBP_OP_IDLE;
        end
      endcase
    end
  end

  assign start   = (op_now != MHBP_OP_IDLE) && (op_now != st_r.op);
  assign irq_hit = start && is_irq_reg(st_r.addr);

  always_comb begin
    st_nxt        = st_r;
    st_nxt.ale_d  = ale_s;
    st_nxt.op     = op_now;
    st_nxt.wr_stb = 1'b0;
    st_nxt.rd_stb = 1'b0;
    // latch address on strobe fall
    if (st_r.ale_d && !ale_s) begin
      st_nxt.addr = bus_s;
    end
    // sample write data while write held
    if (op_now == MHBP_OP_WR_SEP || op_now == MHBP_OP_WR_EN) begin
      st_nxt.wdata = bus_s;
    end
    // commit at end of write
    if ((st_r.op == MHBP_OP_WR_SEP || st_r.op == MHBP_OP_WR_EN) && op_now != st_r.op) begin
      st_nxt.mem[st_r.addr] = st_r.wdata;
      st_nxt.wr_stb         = 1'b1;
      st_nxt.core_addr      = st_r.addr;
      st_nxt.core_wdata     = st_r.wdata;
      st_nxt.region         = region_of(st_r.addr);
    end
    // read data drive
    if (op_now == MHBP_OP_READ) begin
      st_nxt.doe  = 1'b1;
      st_nxt.dout = st_r.mem[st_r.addr];
      if (st_r.op != MHBP_OP_READ) begin
        st_nxt.rd_stb    = 1'b1;
        st_nxt.core_addr = st_r.addr;
        st_nxt.region    = region_of(st_r.addr);
      end
    end else begin
      st_nxt.doe  = 1'b0;
      st_nxt.dout = MHBP_BYTE_ZERO;
    end
    // interrupt release pulse
    if ((IRQ_CLEARED && IRQ_PENDING) || irq_hit) begin
      st_nxt.pcnt = MHBP_INT_PULSE_CYC;
    end else if (st_r.pcnt != MHBP_PCNT_ZERO) begin
      st_nxt.pcnt = st_r.pcnt - MHBP_PCNT_ONE;
    end
    st_nxt.int_oe = IRQ_PENDING && (st_nxt.pcnt == MHBP_PCNT_ZERO);
    // clock out only outside reset
    st_nxt.buffered_clock_out = !st_r.buffered_clock_out;
    st_nxt.ck_oe = 1'b1;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign MUXED_BUS_O        = st_r.dout;
  assign MUXED_BUS_OE       = st_r.doe;
  assign INT_N_O            = 1'b0;
  assign INT_N_OE           = st_r.int_oe;
  assign BUFFERED_CLOCK_OUT = st_r.buffered_clock_out;
  assign BUFFERED_CLOCK_OE  = st_r.ck_oe;
  assign CORE_WR_STB        = st_r.wr_stb;
  assign CORE_RD_STB        = st_r.rd_stb;
  assign CORE_ADDR          = st_r.core_addr;
  assign CORE_WDATA         = st_r.core_wdata;
  assign CORE_REGION        = st_r.region;
endmodule

/* sim/mhbp_asserts.sv */
`timescale 1ns/1ps
module mhbp_asserts (
  input wire logic       CORE_CLK,
  input wire logic       ARST_N,
  input wire logic       READ_N,
  input wire logic       WRITE_DIR,
  input wire logic       SELECT_EN,
  input wire logic       IRQ_PENDING,
  input wire logic       IRQ_CLEARED,
  input wire logic [7:0] MUXED_BUS_O,
  input wire logic       MUXED_BUS_OE,
  input wire logic       INT_N_OE,
  input wire logic       BUFFERED_CLOCK_OUT,
  input wire logic       BUFFERED_CLOCK_OE,
  input wire logic       CORE_WR_STB,
  input wire logic       CORE_RD_STB,
  input wire logic [7:0] CORE_ADDR,
  input wire logic [1:0] CORE_REGION
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  wire       rd_p = SELECT_EN && !READ_N && WRITE_DIR;
  wire [1:0] rg_x = (CORE_ADDR <= 8'h0A) ? 2'h0 : (CORE_ADDR >= 8'h80) ? 2'h2 :
                    (CORE_ADDR >= 8'h10) ? 2'h1 : 2'h3;
  ck_on_a: assert property ($past(ARST_N) |-> BUFFERED_CLOCK_OE)
    else $error("clock out off");
  ck_run_a: assert property ($past(ARST_N) |-> BUFFERED_CLOCK_OUT != $past(BUFFERED_CLOCK_OUT))
    else $error("clock out stuck");
  oe_rd_a: assert property (
    MUXED_BUS_OE |-> $past(rd_p, 3) || $past(rd_p, 4) || $past(rd_p, 5))
    else $error("bus driven outside read");
  oe_hold_a: assert property (
    $past(rd_p, 1) && $past(rd_p, 2) && $past(rd_p, 3) |-> MUXED_BUS_OE)
    else $error("read not driven");
  rd_stb_a: assert property (CORE_RD_STB |-> MUXED_BUS_OE ##1 !CORE_RD_STB)
    else $error("read strobe without drive");
  bus_zero_a: assert property (!MUXED_BUS_OE |-> MUXED_BUS_O == 8'h00)
    else $error("idle bus data");
  wr_rg_a: assert property (CORE_WR_STB |-> CORE_REGION == rg_x ##1 !CORE_WR_STB)
    else $error("write strobe or region");
  int_pd_a: assert property (INT_N_OE |-> $past(IRQ_PENDING))
    else $error("interrupt without pending");
  int_gap_a: assert property (IRQ_CLEARED && IRQ_PENDING |=> !INT_N_OE [*2])
    else $error("no release pulse");
endmodule
bind mhbp_port mhbp_asserts u_chk (.CORE_CLK, .ARST_N, .READ_N, .WRITE_DIR, .SELECT_EN,
  .IRQ_PENDING, .IRQ_CLEARED, .MUXED_BUS_O, .MUXED_BUS_OE, .INT_N_OE, .BUFFERED_CLOCK_OUT,
  .BUFFERED_CLOCK_OE, .CORE_WR_STB, .CORE_RD_STB, .CORE_ADDR, .CORE_REGION);

/* sim/mhbp_host.sv */
`timescale 1ns/1ps
module mhbp_host (
  input  wire logic       clk,
  input  wire logic [7:0] bus_lvl,
  output logic      [7:0] drv_d,
  output logic            drv_oe,
  output logic            ale,
  output logic            rd_n,
  output logic            wr_dir,
  output logic            sel
);
  logic en_st;
  initial begin
    {drv_d, drv_oe, ale, rd_n, wr_dir, sel, en_st} = {8'h00, 6'b001100};
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // select low across style change
  task automatic style(input logic e);
    sel = 1'b0;
    en_st = e;
    rd_n = !e;
    step(4);
  endtask
  task automatic adr(input logic [7:0] a);
    drv_d = a;
    drv_oe = 1'b1;
    ale = 1'b1;
    step(3);
    ale = 1'b0;
    step(3);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    adr(a);
    drv_d = d;
    wr_dir = 1'b0;
    sel = 1'b1;
    step(4);
    if (en_st) sel = 1'b0;
    else wr_dir = 1'b1;
    step(2);
    sel = 1'b0;
    wr_dir = 1'b1;
    drv_oe = 1'b0;
    step(4);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    adr(a);
    drv_oe = 1'b0;
    rd_n = 1'b0;
    sel = 1'b1;
    step(6);
    d = bus_lvl;
    sel = 1'b0;
    rd_n = !en_st;
    step(5);
  endtask
endmodule

/* sim/mhbp_port_bench.sv */
`timescale 1ns/1ps
module mhbp_port_bench;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       pend = 1'b0;
  logic       clr = 1'b0;
  logic [7:0] last_q = 8'h00;
  logic [7:0] bus_o, h_d, a_q, d_q, r, n;
  logic [1:0] rg;
  logic       bus_oe, h_oe, ale, rd_n, wr_dir, sel, int_oe, ck_oe;
  int         mismatches = 0;
  int         tests_run = 0;
  wire  [7:0] bus_lvl = (bus_oe === 1'b1) ? bus_o : ((h_oe === 1'b1) ? h_d : ~last_q);
  always #5 clk = ~clk;
  always @(posedge clk) last_q <= bus_lvl;
  mhbp_port uut (.CORE_CLK(clk), .ARST_N(arst_n), .MUXED_BUS_I(bus_lvl), .MUXED_BUS_O(bus_o),
    .MUXED_BUS_OE(bus_oe), .ADDR_LATCH(ale), .READ_N(rd_n), .WRITE_DIR(wr_dir),
    .SELECT_EN(sel), .IRQ_PENDING(pend), .IRQ_CLEARED(clr), .INT_N_O(), .INT_N_OE(int_oe),
    .BUFFERED_CLOCK_OUT(), .BUFFERED_CLOCK_OE(ck_oe), .CORE_WR_STB(), .CORE_RD_STB(),
    .CORE_ADDR(a_q), .CORE_WDATA(d_q), .CORE_REGION(rg));
  mhbp_host host (.clk(clk), .bus_lvl(bus_lvl), .drv_d(h_d), .drv_oe(h_oe), .ale(ale),
    .rd_n(rd_n), .wr_dir(wr_dir), .sel(sel));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_sep();
    check({7'h00, ck_oe}, 8'h01);
    host.style(1'b0);
    host.wr(8'h85, 8'h3C);
    check(a_q, 8'h85);
    check(d_q, 8'h3C);
    check({6'h00, rg}, 8'h02);
    host.rd(8'h85, r);
    check(r, 8'h3C);
    check({7'h00, bus_oe}, 8'h00);
    $display("t_sep done");
  endtask
  task automatic t_en();
    host.style(1'b1);
    host.wr(8'h12, 8'hA5);
    check({6'h00, rg}, 8'h01);
    host.wr(8'h0A, 8'h5A);
    check({6'h00, rg}, 8'h00);
    host.rd(8'h12, r);
    check(r, 8'hA5);
    host.rd(8'h85, r);
    check(r, 8'h3C);
    $display("t_en done");
  endtask
  task automatic t_irq();
    n = 8'h00;
    pend = 1'b1;
    repeat (3) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (6) begin
      n = n + {7'h00, !int_oe};
      @(negedge clk);
    end
    check(n, 8'h02);
    n = 8'h00;
    fork
      host.rd(8'h09, r);
      repeat (20) begin
        @(negedge clk);
        n = n + {7'h00, !int_oe};
      end
    join
    check(n, 8'h02);
    $display("t_irq done");
  endtask
  task automatic t_rst();
    @(negedge clk);
    arst_n = 1'b0;
    #1;
    check({6'h00, ck_oe, int_oe}, 8'h00);
    check({7'h00, bus_oe}, 8'h00);
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    check({7'h00, ck_oe}, 8'h01);
    host.rd(8'h85, r);
    check(r, 8'h00);
    $display("t_rst done");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_sep();
    t_en();
    t_irq();
    t_rst();
    print_verdict();
  end
endmodule
